// ### phy_link_power_pkg.sv
package phy_link_power_pkg;
  // Timing
  localparam int CLK_PERIOD_NS        = 20;
  localparam int RESET_INTERVAL_NS    = 2600;
  localparam int RESET_CYCLES         = (RESET_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DISABLE_INTERVAL_NS  = 25000;
  localparam int DISABLE_CYCLES       = (DISABLE_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOW_COUNT_W          = $clog2(DISABLE_CYCLES + 1);
  localparam int POWERUP_WAKE_US      = 167;
  localparam int POWERUP_WAKE_CYCLES  = (POWERUP_WAKE_US * 1000) / CLK_PERIOD_NS;
  localparam int WAKE_HALF_NS         = 160;
  localparam int WAKE_HALF_CYCLES     = WAKE_HALF_NS / CLK_PERIOD_NS;
  localparam logic [2:0] MAX_WAKE_POWER_CLASS = 3'h4;
  // Synchronised pin positions
  localparam int PIN_LPS   = 0;
  localparam int PIN_CPS   = 1;
  localparam int PIN_LCLK  = 2;
  localparam int PIN_BSEL  = 3;
  localparam int PIN_LINK_REQUEST_INPUT  = 4;
  localparam int PIN_COUNT = 5;
  // Register map
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] EVENT_ADDR  = 8'h08;
  localparam int CTRL_LINK_ACTIVE  = 0;
  localparam int CTRL_WAKE_ON_INT  = 1;
  localparam int CTRL_CABLE_INT_EN = 2;
  localparam int CTRL_PORT_INT_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h00000003;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_WAKE      = 2;
  localparam int STAT_PMC       = 3;
  localparam int STAT_INTERFACE_PROTOCOL_SELECT     = 4;
  localparam int STAT_LPS_ACT   = 5;
  localparam int STAT_LINK_RDY  = 6;
  localparam int EVT_CABLE_LOST = 0;
  localparam int EVT_LCLK_SEEN  = 1;
  localparam int EVT_PORT_LSB   = 4;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {IF_ACTIVE, IF_RESET, IF_DISABLED} iface_type;
endpackage : phy_link_power_pkg

// ### phy_link_power_manager.sv
`timescale 1ns/1ps
module phy_link_power_manager
  import phy_link_power_pkg::*;
#(
  parameter int NPORTS       = 3,
  parameter int POWERUP_WAKE = POWERUP_WAKE_CYCLES
)(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // Link-side pins
  input  wire logic              linkPowerStatus,
  input  wire logic              cablePowerSense,
  input  wire logic              linkClockStrap,
  input  wire logic              interfaceProtocolSelect,
  input  wire logic              linkRequestInput,
  output logic                   linkWakeOutput,
  input  wire logic [1:0]        ctlIn,
  output logic [1:0]             ctlOut,
  output logic [1:0]             ctlOe,
  input  wire logic [7:0]        dataIn,
  output logic [7:0]             dataOut,
  output logic [7:0]             dataOe,
  // Core side
  input  wire logic [NPORTS-1:0] portStateChange,
  input  wire logic              linkOnPacket,
  input  wire logic              busResetEvent,
  input  wire logic [2:0]        powerClass,
  input  wire logic [1:0]        coreCtlOut,
  input  wire logic [1:0]        coreCtlOe,
  input  wire logic [7:0]        coreDataOut,
  input  wire logic [7:0]        coreDataOe,
  output logic [1:0]             linkCtlSeen,
  output logic [7:0]             linkDataSeen,
  output logic                   linkRequestOut,
  output logic [3:0]             powerControlLines,
  output logic                   busResetRequest,
  output logic                   selfIdLinkActive,
  output logic                   phyClockEnable,
  output logic                   protocolB,
  output logic                   pmcMode
);
  localparam int HALF_W = $clog2(WAKE_HALF_CYCLES + 1);
  localparam int PWR_W  = $clog2(POWERUP_WAKE + 1);
  localparam logic [31:0] CTRL_MASK =
    32'((1 << (CTRL_PORT_INT_LSB + NPORTS)) - 1) & 32'hfffffff7;

  logic [PIN_COUNT-1:0]   pinRaw;
  logic [PIN_COUNT-1:0]   pinSync1;
  logic [PIN_COUNT-1:0]   pinSync2;
  logic [LOW_COUNT_W-1:0] lowCount;
  logic                   lpsInactive;
  logic                   disableReached;
  iface_type              ifState;
  iface_type              next_ifState;
  logic [31:0]            ctrl;
  logic                   linkActiveBit;
  logic                   linkReady;
  logic                   linkInactive;
  logic [NPORTS-1:0]      portPending;
  logic                   cableLost;
  logic                   cablePrev;
  logic                   cableFall;
  logic                   lclkPrev;
  logic                   lclkSeen;
  logic                   phyIntCond;
  logic                   wakeSet;
  logic                   wakeActive;
  logic                   afterReset;
  logic [PWR_W-1:0]       powerUpCount;
  logic                   wakeOn;
  logic [HALF_W-1:0]      halfCount;
  logic                   wakeTick;
  logic                   dWrite;
  logic [7:0]             dAddr;
  logic                   addrPhase;
  logic [31:0]            evtClear;

  // Status, strap, select and request pins cross two flops before any logic looks at them; ctlIn and dataIn do not
  assign pinRaw = {linkRequestInput, interfaceProtocolSelect, linkClockStrap,
                   cablePowerSense, linkPowerStatus};

  always_ff @(posedge clk)
  begin
    pinSync1 <= pinRaw;
    pinSync2 <= pinSync1;
  end

  // Low-time counter, saturates at the disable interval
  always_ff @(posedge clk)
  begin
    if (rst)
      lowCount <= '0;
    else if (pinSync2[PIN_LPS])
      lowCount <= '0;
    else if (!disableReached)
      lowCount <= lowCount + LOW_COUNT_W'(1);
  end

  assign lpsInactive    = lowCount > LOW_COUNT_W'(RESET_CYCLES);
  assign disableReached = lowCount == LOW_COUNT_W'(DISABLE_CYCLES);

  // Interface state ignores the link-active bit; repeater logic is never gated here
  always_comb
  begin
    next_ifState = ifState;
    unique case (ifState)
      IF_ACTIVE:   if (lpsInactive) next_ifState = IF_RESET;
      IF_RESET:
      begin
        if (!lpsInactive)
          next_ifState = IF_ACTIVE;
        else if (disableReached)
          next_ifState = IF_DISABLED;
      end
      IF_DISABLED: if (!lpsInactive) next_ifState = IF_ACTIVE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      ifState <= IF_RESET;
    else
      ifState <= next_ifState;
  end

  // Lines held low outside the active state; upper data lines go to power control
  always_ff @(posedge clk)
  begin
    if (rst || ifState != IF_ACTIVE)
    begin
      ctlOut         <= '0;
      ctlOe          <= 2'h3;
      dataOut        <= '0;
      dataOe         <= 8'hff;
      linkCtlSeen    <= '0;
      linkDataSeen   <= '0;
      linkRequestOut <= 1'b0;
    end
    else
    begin
      ctlOut         <= coreCtlOut;
      ctlOe          <= coreCtlOe;
      dataOut        <= coreDataOut;
      dataOe         <= pmcMode ? {4'h0, coreDataOe[3:0]} : coreDataOe;
      linkCtlSeen    <= ctlIn;
      linkDataSeen   <= dataIn;
      linkRequestOut <= pinSync2[PIN_LINK_REQUEST_INPUT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      powerControlLines <= '0;
    else
      powerControlLines <= pmcMode ? dataIn[7:4] : 4'h0;
  end

  // Strap caught while reset is held, so no async path carries it
  always_ff @(posedge clk)
  begin
    if (rst)
      pmcMode <= pinSync2[PIN_LCLK];
  end

  // Board must not change the select pin in operation
  always_ff @(posedge clk)
  begin
    if (rst)
      protocolB <= 1'b0;
    else
      protocolB <= pinSync2[PIN_BSEL];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      phyClockEnable   <= 1'b0;
      selfIdLinkActive <= 1'b0;
      busResetRequest  <= 1'b0;
    end
    else
    begin
      phyClockEnable   <= ifState != IF_DISABLED;
      selfIdLinkActive <= linkReady;
      busResetRequest  <= disableReached && pinSync2[PIN_LPS];
    end
  end

  assign linkActiveBit = ctrl[CTRL_LINK_ACTIVE];
  assign linkReady     = !lpsInactive && linkActiveBit;
  assign linkInactive  = !linkReady;

  // Interrupt sources; hardware set beats software clear
  assign cableFall = cablePrev && !pinSync2[PIN_CPS];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cablePrev <= 1'b0;
      lclkPrev  <= 1'b0;
    end
    else
    begin
      cablePrev <= pinSync2[PIN_CPS];
      lclkPrev  <= pinSync2[PIN_LCLK];
    end
  end

  genvar p;
  generate
    for (p = 0; p < NPORTS; p++)
    begin : g_port
      always_ff @(posedge clk)
      begin
        if (rst)
          portPending[p] <= 1'b0;
        else if (portStateChange[p] && ctrl[CTRL_PORT_INT_LSB + p])
          portPending[p] <= 1'b1;
        else if (evtClear[EVT_PORT_LSB + p])
          portPending[p] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (rst)
      cableLost <= 1'b0;
    else if (cableFall && ctrl[CTRL_CABLE_INT_EN])
      cableLost <= 1'b1;
    else if (evtClear[EVT_CABLE_LOST])
      cableLost <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      lclkSeen <= 1'b0;
    else if (lclkPrev != pinSync2[PIN_LCLK])
      lclkSeen <= 1'b1;
    else if (evtClear[EVT_LCLK_SEEN])
      lclkSeen <= 1'b0;
  end

  assign phyIntCond = (|portPending || cableLost) && ctrl[CTRL_WAKE_ON_INT];
  assign wakeSet    = linkInactive && (linkOnPacket || phyIntCond);

  always_ff @(posedge clk)
  begin
    if (rst)
      wakeActive <= 1'b0;
    else if (wakeSet)
      wakeActive <= 1'b1;
    else if (linkReady)
      wakeActive <= 1'b0;
    else if (busResetEvent && !phyIntCond)
      wakeActive <= 1'b0;
  end

  // Power-up wake window, cut short when the link comes up
  always_ff @(posedge clk)
  begin
    if (rst)
      afterReset <= 1'b1;
    else
      afterReset <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      powerUpCount <= '0;
    // Idle counter reads active after reset, so only a pin seen high cuts the window
    else if (linkReady && pinSync2[PIN_LPS])
      powerUpCount <= '0;
    else if (afterReset && powerClass <= MAX_WAKE_POWER_CLASS)
      powerUpCount <= PWR_W'(POWERUP_WAKE);
    else if (powerUpCount != '0)
      powerUpCount <= powerUpCount - PWR_W'(1);
  end

  assign wakeOn   = wakeActive || powerUpCount != '0;
  assign wakeTick = halfCount == HALF_W'(WAKE_HALF_CYCLES - 1);

  always_ff @(posedge clk)
  begin
    if (rst || !wakeOn)
    begin
      halfCount      <= '0;
      linkWakeOutput <= 1'b0;
    end
    else if (wakeTick)
    begin
      halfCount      <= '0;
      linkWakeOutput <= !linkWakeOutput;
    end
    else
      halfCount <= halfCount + HALF_W'(1);
  end

  // Bus slave: zero wait states, read data registered in the address phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addrPhase = hsel && hready && htrans == HTRANS_NONSEQ;
  assign evtClear  = (dWrite && dAddr == EVENT_ADDR) ? hwdata : 32'h0;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dWrite <= 1'b0;
      dAddr  <= '0;
    end
    else
    begin
      dWrite <= addrPhase && hwrite;
      dAddr  <= haddr[7:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl <= CTRL_RESET;
    else if (dWrite && dAddr == CTRL_ADDR)
      ctrl <= hwdata & CTRL_MASK;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      hrdata <= '0;
    else if (addrPhase && !hwrite)
    begin
      hrdata <= '0;
      unique case (haddr[7:0])
        CTRL_ADDR:   hrdata <= ctrl;
        STATUS_ADDR:
        begin
          hrdata[STAT_STATE_LSB +: 2] <= ifState;
          hrdata[STAT_WAKE]           <= wakeOn;
          hrdata[STAT_PMC]            <= pmcMode;
          hrdata[STAT_INTERFACE_PROTOCOL_SELECT]          <= protocolB;
          hrdata[STAT_LPS_ACT]        <= !lpsInactive;
          hrdata[STAT_LINK_RDY]       <= linkReady;
        end
        EVENT_ADDR:
        begin
          hrdata[EVT_CABLE_LOST]              <= cableLost;
          hrdata[EVT_LCLK_SEEN]               <= lclkSeen;
          hrdata[EVT_PORT_LSB +: NPORTS]      <= portPending;
        end
        default:     hrdata <= '0;
      endcase
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_disabled_return;
    ifState == IF_DISABLED ##0 $rose(pinSync2[PIN_LPS]);
  endsequence

  sequence s_idle_side;
    ifState != IF_ACTIVE;
  endsequence

  AST_RESET_ENTRY: assert property (ifState == IF_ACTIVE && lpsInactive |=> ifState == IF_RESET)
    else $error("interface did not enter reset state");
  AST_LINES_ZERO: assert property (s_idle_side |=> ctlOut == 2'h0 && dataOut == 8'h0 && !linkRequestOut)
    else $error("lines not held low outside active state");
  AST_STATUS_HIGH: assert property (pinSync2[PIN_LPS] |=> !lpsInactive ##1 !lpsInactive)
    else $error("status taken inactive while high");
  AST_CLOCK_STOP: assert property (ifState == IF_DISABLED |=> !phyClockEnable)
    else $error("PHY clock running while disabled");
  AST_BUS_RESET: assert property (s_disabled_return |=> busResetRequest ##1 !busResetRequest)
    else $error("bus reset not issued once on return");
  AST_WAKE_TOGGLE: assert property (wakeOn && wakeTick |=> linkWakeOutput != $past(linkWakeOutput))
    else $error("wake output did not toggle");
  AST_WAKE_START: assert property (linkInactive && linkOnPacket |=> wakeOn ##[1:8] halfCount != '0)
    else $error("wake not started on link-on packet");
  AST_WAKE_STOP: assert property (
    linkReady && pinSync2[PIN_LPS] && !wakeSet |=> !wakeOn ##1 !linkWakeOutput)
    else $error("wake not stopped when link ready");
  AST_BUSRESET_STOP: assert property (busResetEvent && !phyIntCond && !wakeSet |=> !wakeActive)
    else $error("bus reset did not stop wake");
  AST_POWERUP: assert property (
    afterReset && !(linkReady && pinSync2[PIN_LPS]) && powerClass <= MAX_WAKE_POWER_CLASS
    |=> powerUpCount == PWR_W'(POWERUP_WAKE))
    else $error("power-up wake window not loaded");
  AST_CABLE_LOSS: assert property (cableFall && ctrl[CTRL_CABLE_INT_EN] |=> cableLost)
    else $error("cable power loss not flagged");
endmodule : phy_link_power_manager

// ### link_layer_model.sv
`timescale 1ns/1ps
module link_layer_model (
  // Commands from the bench
  input  wire logic       powerOn,
  input  wire logic       requestOn,
  input  wire logic       clockRun,
  input  wire logic       strapLevel,
  // Pins toward the PHY
  output logic            linkPowerStatus,
  output logic            linkRequestInput,
  output logic            linkClockStrap,
  input  wire logic [1:0] ctlOe,
  input  wire logic [7:0] dataOe,
  output logic [1:0]      ctlDrive,
  output logic [1:0]      ctlDriveOe,
  output logic [7:0]      dataDrive,
  output logic [7:0]      dataDriveOe
);
  logic linkClk = 1'b0;

  // Offset keeps link clock edges clear of system clock edges
  initial #7 forever #80 linkClk = ~linkClk;

  assign linkPowerStatus  = powerOn;
  assign linkRequestInput = requestOn;
  // Strap level holds until the clock is started after reset
  assign linkClockStrap = clockRun ? linkClk : strapLevel;
  // Link drives only the lines the PHY has released
  assign ctlDriveOe  = ~ctlOe;
  assign ctlDrive    = 2'h2;
  assign dataDriveOe = ~dataOe;
  assign dataDrive   = 8'h96;
endmodule : link_layer_model

// ### phy_link_power_manager_tb.sv
`timescale 1ns/1ps
module phy_link_power_manager_tb;
  import phy_link_power_pkg::*;
  localparam int LIMIT = 20000;
  logic clk = 1'b0, rst = 1'b1, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0, ctlIn, ctlOut, ctlOe, ctlDrive, ctlDriveOe, linkCtlSeen;
  logic [7:0] dataIn, dataOut, dataOe, dataDrive, dataDriveOe, linkDataSeen;
  logic powerOn = 1'b1, requestOn = 1'b1, clockRun = 1'b0, cablePowerSense = 1'b1;
  logic strapLevel = 1'b1, protocolSel = 1'b1;
  logic [2:0] powerClass = 3'h5;
  logic [1:0] coreCtlOut = 2'h1, coreCtlOe = 2'h0;
  logic [7:0] coreDataOut = 8'h03, coreDataOe = 8'hff;
  logic linkPowerStatus, linkRequestInput, linkClockStrap, linkWakeOutput;
  logic [2:0] portStateChange = 3'h0;
  logic linkOnPacket = 1'b0, busResetEvent = 1'b0;
  logic linkRequestOut, busResetRequest, selfIdLinkActive, phyClockEnable, protocolB, pmcMode;
  logic [3:0] powerControlLines;
  int errTotal = 0, nTests = 0, cycles = 0;

  always #10 clk = ~clk;

  // Lines with nobody driving fall to 0
  assign ctlIn  = (ctlOe & ctlOut) | (ctlDriveOe & ctlDrive);
  assign dataIn = (dataOe & dataOut) | (dataDriveOe & dataDrive);

  phy_link_power_manager #(.NPORTS(3), .POWERUP_WAKE(40)) dut (
    .clk(clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .linkPowerStatus(linkPowerStatus),
    .cablePowerSense(cablePowerSense), .linkClockStrap(linkClockStrap),
    .interfaceProtocolSelect(protocolSel), .linkRequestInput(linkRequestInput),
    .linkWakeOutput(linkWakeOutput), .ctlIn(ctlIn), .ctlOut(ctlOut), .ctlOe(ctlOe),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .portStateChange(portStateChange), .linkOnPacket(linkOnPacket),
    .busResetEvent(busResetEvent), .powerClass(powerClass), .coreCtlOut(coreCtlOut),
    .coreCtlOe(coreCtlOe), .coreDataOut(coreDataOut), .coreDataOe(coreDataOe),
    .linkCtlSeen(linkCtlSeen), .linkDataSeen(linkDataSeen),
    .linkRequestOut(linkRequestOut), .powerControlLines(powerControlLines),
    .busResetRequest(busResetRequest), .selfIdLinkActive(selfIdLinkActive),
    .phyClockEnable(phyClockEnable), .protocolB(protocolB), .pmcMode(pmcMode)
  );

  link_layer_model lnk (
    .powerOn(powerOn), .requestOn(requestOn), .clockRun(clockRun), .strapLevel(strapLevel),
    .linkPowerStatus(linkPowerStatus), .linkRequestInput(linkRequestInput),
    .linkClockStrap(linkClockStrap), .ctlOe(ctlOe), .dataOe(dataOe),
    .ctlDrive(ctlDrive), .ctlDriveOe(ctlDriveOe), .dataDrive(dataDrive),
    .dataDriveOe(dataDriveOe)
  );

  task automatic conclude;
    $display("Checks made %0d, mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp)
    begin
      errTotal++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task automatic busCycle(input logic [7:0] a, input logic w, input logic [31:0] d,
                          output logic [31:0] q);
    @(posedge clk);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask : busCycle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    busCycle(a, 1'b1, d, q);
  endtask : wr

  task automatic pulse(input int which);
    @(posedge clk);
    if (which == 0) linkOnPacket <= 1'b1;
    if (which == 1) portStateChange <= 3'h1;
    if (which == 2) busResetEvent <= 1'b1;
    @(posedge clk);
    linkOnPacket    <= 1'b0;
    portStateChange <= 3'h0;
    busResetEvent   <= 1'b0;
  endtask : pulse

  task automatic waitWake(input logic lvl, input int lim, output int n);
    n = 0;
    while (linkWakeOutput !== lvl && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  endtask : waitWake

  task automatic quietWake(output int highs);
    highs = 0;
    repeat (5) @(posedge clk);
    repeat (20)
    begin
      @(posedge clk);
      if (linkWakeOutput !== 1'b0) highs++;
    end
  endtask : quietWake

  task automatic testReset;
    logic [31:0] q;
    busCycle(CTRL_ADDR, 1'b0, 32'h0, q);
    check("ctrl reset", CTRL_RESET, q);
    busCycle(STATUS_ADDR, 1'b0, 32'h0, q);
    check("state", {30'h0, IF_ACTIVE}, q[1:0]);
    busCycle(8'h0c, 1'b0, 32'h0, q);
    check("unmapped", 32'h0, q);
    check("pmc mode", 1, pmcMode);
    check("protocol", 1, protocolB);
    check("ctl seen", 2'h2, linkCtlSeen);
    check("data seen", 8'h93, linkDataSeen);
    check("pmc lines", 4'h9, powerControlLines);
    check("data oe pmc", 8'h0f, dataOe);
    check("request", 1, linkRequestOut);
    check("hresp", 0, hresp);
    @(posedge clk);
    coreCtlOe <= 2'h3;
    repeat (3) @(posedge clk);
    check("ctl driven", 2'h1, ctlOut);
    check("ctl oe", 2'h3, ctlOe);
    check("ctl seen driven", 2'h1, linkCtlSeen);
    coreCtlOe <= 2'h0;
  endtask : testReset

  task automatic testStatusLow;
    logic [31:0] q;
    @(posedge clk);
    powerOn <= 1'b0;
    repeat (100) @(posedge clk);
    busCycle(STATUS_ADDR, 1'b0, 32'h0, q);
    check("state short low", {30'h0, IF_ACTIVE}, q[1:0]);
    repeat (40) @(posedge clk);
    busCycle(STATUS_ADDR, 1'b0, 32'h0, q);
    check("state long low", {30'h0, IF_RESET}, q[1:0]);
    check("ctl out", 2'h0, ctlOut);
    check("ctl oe idle", 2'h3, ctlOe);
    check("data out", 8'h00, dataOut);
    check("request ignored", 0, linkRequestOut);
    check("clock kept", 1, phyClockEnable);
    repeat (1150) @(posedge clk);
    busCycle(STATUS_ADDR, 1'b0, 32'h0, q);
    check("state disabled", {30'h0, IF_DISABLED}, q[1:0]);
    check("clock stopped", 0, phyClockEnable);
  endtask : testStatusLow

  task automatic testReturn;
    int n;
    @(posedge clk);
    powerOn <= 1'b1;
    n = 0;
    while (busResetRequest !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    check("bus reset issued", 1, n < 20);
    @(posedge clk);
    check("bus reset single", 0, busResetRequest);
    repeat (4) @(posedge clk);
    check("self id link flag", 1, selfIdLinkActive);
    check("clock back", 1, phyClockEnable);
  endtask : testReturn

  task automatic testWakePacket;
    logic [31:0] q;
    int n;
    wr(CTRL_ADDR, 32'h2);
    busCycle(STATUS_ADDR, 1'b0, 32'h0, q);
    check("state with bit clear", {30'h0, IF_ACTIVE}, q[1:0]);
    pulse(0);
    waitWake(1'b1, 30, n);
    check("wake on packet", 1, n < 30);
    waitWake(1'b0, 20, n);
    check("wake half period", WAKE_HALF_CYCLES, n);
    wr(CTRL_ADDR, CTRL_RESET);
    quietWake(n);
    check("wake after ready", 0, n);
  endtask : testWakePacket

  task automatic testWakeInterrupt;
    logic [31:0] q;
    int n;
    wr(CTRL_ADDR, 32'h13);
    @(posedge clk);
    powerOn <= 1'b0;
    repeat (140) @(posedge clk);
    pulse(1);
    waitWake(1'b1, 30, n);
    check("wake on port change", 1, n < 30);
    busCycle(EVENT_ADDR, 1'b0, 32'h0, q);
    check("port event", 1, q[EVT_PORT_LSB]);
    pulse(2);
    waitWake(1'b0, 20, n);
    waitWake(1'b1, 20, n);
    check("wake kept by pending", 1, n < 20);
    wr(EVENT_ADDR, 32'h10);
    pulse(2);
    quietWake(n);
    check("wake after bus reset", 0, n);
    @(posedge clk);
    powerOn <= 1'b1;
    repeat (10) @(posedge clk);
  endtask : testWakeInterrupt

  task automatic testCable;
    logic [31:0] q;
    wr(CTRL_ADDR, 32'h7);
    @(posedge clk);
    cablePowerSense <= 1'b0;
    repeat (5) @(posedge clk);
    busCycle(EVENT_ADDR, 1'b0, 32'h0, q);
    check("cable lost", 1, q[EVT_CABLE_LOST]);
    check("link clock edges", 1, q[EVT_LCLK_SEEN]);
    wr(EVENT_ADDR, 32'h1);
    busCycle(EVENT_ADDR, 1'b0, 32'h0, q);
    check("cable lost cleared", 0, q[EVT_CABLE_LOST]);
  endtask : testCable

  // Second reset with status low, low power class, strap and select low
  task automatic testPowerUp;
    int n;
    @(posedge clk);
    rst         <= 1'b1;
    clockRun    <= 1'b0;
    strapLevel  <= 1'b0;
    protocolSel <= 1'b0;
    powerOn     <= 1'b0;
    powerClass  <= 3'h2;
    repeat (16) @(posedge clk);
    rst      <= 1'b0;
    clockRun <= 1'b1;
    waitWake(1'b1, 30, n);
    check("power-up wake", 1, n < 30);
    check("pmc mode off", 0, pmcMode);
    check("protocol legacy", 0, protocolB);
    check("pmc lines off", 4'h0, powerControlLines);
    check("data oe full", 8'hff, dataOe);
    @(posedge clk);
    powerOn <= 1'b1;
    quietWake(n);
    check("power-up cut short", 0, n);
  endtask : testPowerUp

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      errTotal++;
      conclude();
    end
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rst      <= 1'b0;
    clockRun <= 1'b1;
    testReset();
    testStatusLow();
    testReturn();
    testWakePacket();
    testWakeInterrupt();
    testCable();
    testPowerUp();
    conclude();
  end
endmodule : phy_link_power_manager_tb
